//--- pkg/diag_record_regs.svh
// Offsets, field positions, fixed values and timing of the diagnostic record
`ifndef DIAG_RECORD_REGS_SVH
`define DIAG_RECORD_REGS_SVH

// ---------------------------------------------------------------
// Access selectors
// ---------------------------------------------------------------
`define SET_SHORT         16'h0000
`define SET_FULL          16'h0001
`define CAN_SHORT         16'h2F00
`define CAN_FULL          16'h2F01
`define ECAT_INDEX        16'h5005
`define REC_LEN           5'h14
`define SHORT_LEN         5'h04
`define STAMP_FIRST_BYTE  5'h10
`define STAMP_LEN         5'h04

// ---------------------------------------------------------------
// Byte offsets (subindex numbers)
// ---------------------------------------------------------------
`define OFS_SUMMARY       8'h02
`define OFS_CLASS         8'h03
`define OFS_RSVD_FAULT    8'h04
`define OFS_INTERNAL      8'h05
`define OFS_KIND          8'h06
`define OFS_BITS          8'h07
`define OFS_COUNT         8'h08
`define OFS_GROUP         8'h09
`define OFS_CH0           8'h0A
`define OFS_CH1           8'h0B
`define OFS_UNUSED_FIRST  8'h0C
`define OFS_UNUSED_LAST   8'h11
`define OFS_STAMP         8'h13

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SUM_MODULE_FAIL   0
`define SUM_INTERNAL      1
`define SUM_EXTERNAL      2
`define SUM_CHANNEL       3
`define SUM_AUX_MISSING   4
`define SUM_PARAM         7
`define INT_BUF_OVERFLOW  3
`define INT_COMM          4
`define CH_CFG_FAULT      0
`define CH_SHORT_GND      3

// ---------------------------------------------------------------
// Reset and fixed values
// ---------------------------------------------------------------
`define FAULT_RESET       8'h00
`define CLASS_VALUE       8'h15
`define KIND_VALUE        8'h73
`define BITS_VALUE        8'h08
`define COUNT_VALUE       8'h02
`define STAMP_RESET       32'h0000_0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TICK_PERIOD_NS    1000
`define CLK_PERIOD_NS     5

`endif

//--- pkg/diag_pkg.sv
// Types shared by the diagnostic record modules
package diag_pkg;

   typedef enum logic [2:0]
   {
      ACC_RECORD   = 3'b001,
      ACC_CANOPEN  = 3'b010,
      ACC_ETHERCAT = 3'b100
   } access_type;

   typedef struct packed
   {
      logic       module_fail;
      logic       int_error;
      logic       ext_error;
      logic       aux_missing;
      logic       param_error;
      logic       buf_overflow;
      logic       comm_error;
      logic [1:0] cfg_fault;
      logic [1:0] short_gnd;
   } fault_in_type;

endpackage

//--- pkg/ticker_if.sv
// Microsecond ticker carrier between ticker and record
`timescale 1ns/1ps
interface ticker_if;
   logic        tick;
   logic [31:0] count;
   modport source (output tick, output count);
   modport sink   (input tick, input count);
endinterface

//--- hw/us_ticker.sv
// Free-running microsecond counter
`timescale 1ns/1ps
`include "diag_record_regs.svh"
module us_ticker
#(
   parameter int CYCLES_PER_US = `TICK_PERIOD_NS / `CLK_PERIOD_NS
)
(
   input  logic     clk,
   input  logic     reset,
   ticker_if.source tk
);
   localparam int            PW       = $clog2(CYCLES_PER_US + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_US - 1);

   logic [PW-1:0] pre_r;
   logic [PW-1:0] pre_nxt;
   logic [31:0]   cnt_r;
   logic [31:0]   cnt_nxt;
   logic          tick_r;
   logic          tick_nxt;

   // ---------------------------------------------------------------
   // Prescaler and counter
   // ---------------------------------------------------------------
   always_comb
   begin
      tick_nxt = (pre_r == PRE_LAST);
      pre_nxt  = tick_nxt ? '0 : pre_r + PW'(1);
      cnt_nxt  = tick_nxt ? cnt_r + 32'h0000_0001 : cnt_r;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pre_r  <= '0;
         cnt_r  <= `STAMP_RESET;
         tick_r <= 1'b0;
      end
      else
      begin
         pre_r  <= pre_nxt;
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tk.tick  = tick_r;
   assign tk.count = cnt_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   count_step_a: assert property (@(posedge clk) disable iff (reset)
      (cnt_r != $past(cnt_r)) |-> (cnt_r == $past(cnt_r) + 32'h0000_0001) && tick_r)
      else $error("microsecond count stepped wrongly");

   tick_space_a: assert property (@(posedge clk) disable iff (reset)
      tick_r |=> !tick_r)
      else $error("microsecond ticks too close");

endmodule // us_ticker

//--- hw/analog_output_diag_record.sv
// Diagnostic record of the two-channel analog output module
`timescale 1ns/1ps
`include "diag_record_regs.svh"

module analog_output_diag_record
#(
   parameter int CYCLES_PER_US = `TICK_PERIOD_NS / `CLK_PERIOD_NS
)
(
   input  logic                 CLK,
   input  logic                 RESET,
   input  logic                 MODULE_FAIL,
   input  logic                 INT_ERROR,
   input  logic                 EXT_ERROR,
   input  logic                 AUX_MISSING,
   input  logic                 PARAM_ERROR,
   input  logic                 BUF_OVERFLOW,
   input  logic                 COMM_ERROR,
   input  logic [1:0]           CFG_FAULT,
   input  logic [1:0]           SHORT_GND,
   input  logic [1:0]           SHORT_EN,
   input  logic                 RD_REQ,
   input  diag_pkg::access_type RD_MODE,
   input  logic [15:0]          RD_SEL,
   input  logic [7:0]           RD_SUB,
   input  logic [4:0]           RD_BYTE,
   input  logic                 WR_REQ,
   output logic                 RD_ACK,
   output logic                 RD_ERR,
   output logic [7:0]           RD_DATA,
   output logic                 WR_REFUSED,
   output logic [1:0]           CH_LED
);
   import diag_pkg::*;

   fault_in_type raw;
   fault_in_type sync1_r;
   fault_in_type sync2_r;

   logic [7:0]   summary_r;
   logic [7:0]   summary_nxt;
   logic [7:0]   internal_r;
   logic [7:0]   internal_nxt;
   logic [7:0]   group_r;
   logic [7:0]   group_nxt;
   logic [7:0]   ch0_r;
   logic [7:0]   ch0_nxt;
   logic [7:0]   ch1_r;
   logic [7:0]   ch1_nxt;
   logic [31:0]  stamp_r;
   logic [31:0]  stamp_nxt;
   logic [1:0]   led_r;
   logic [1:0]   led_nxt;
   logic         rise;

   logic         ack_r;
   logic         ack_nxt;
   logic         err_r;
   logic         err_nxt;
   logic [7:0]   data_r;
   logic [7:0]   data_nxt;
   logic         wref_r;
   logic         wref_nxt;
   logic [7:0]   sel_sub;
   logic [1:0]   sel_part;
   logic         sel_ok;

   ticker_if tk ();

   us_ticker
   #(
      .CYCLES_PER_US (CYCLES_PER_US)
   )
   u_ticker
   (
      .clk   (CLK),
      .reset (RESET),
      .tk    (tk.source)
   );

   // ---------------------------------------------------------------
   // Fault input synchroniser
   // ---------------------------------------------------------------
   always_comb
   begin
      raw.module_fail  = MODULE_FAIL;
      raw.int_error    = INT_ERROR;
      raw.ext_error    = EXT_ERROR;
      raw.aux_missing  = AUX_MISSING;
      raw.param_error  = PARAM_ERROR;
      raw.buf_overflow = BUF_OVERFLOW;
      raw.comm_error   = COMM_ERROR;
      raw.cfg_fault    = CFG_FAULT;
      raw.short_gnd    = SHORT_GND;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= raw;
         sync2_r <= sync1_r;
      end
   end

   // ---------------------------------------------------------------
   // Record contents
   // ---------------------------------------------------------------
   function automatic logic [7:0] channel_byte(input logic cfg, input logic shrt, input logic en);
      logic [7:0] b;
      b                = `FAULT_RESET;
      b[`CH_CFG_FAULT] = cfg;
      b[`CH_SHORT_GND] = shrt & en;
      return b;
   endfunction

   always_comb
   begin
      ch0_nxt   = channel_byte(sync2_r.cfg_fault[0], sync2_r.short_gnd[0], SHORT_EN[0]);
      ch1_nxt   = channel_byte(sync2_r.cfg_fault[1], sync2_r.short_gnd[1], SHORT_EN[1]);
      group_nxt = `FAULT_RESET;
      group_nxt[0] = |ch0_nxt;
      group_nxt[1] = |ch1_nxt;
      internal_nxt = `FAULT_RESET;
      internal_nxt[`INT_BUF_OVERFLOW] = sync2_r.buf_overflow;
      internal_nxt[`INT_COMM]         = sync2_r.comm_error;
      summary_nxt = `FAULT_RESET;
      summary_nxt[`SUM_MODULE_FAIL] = sync2_r.module_fail;
      summary_nxt[`SUM_INTERNAL]    = sync2_r.int_error | (|internal_nxt);
      summary_nxt[`SUM_EXTERNAL]    = sync2_r.ext_error;
      summary_nxt[`SUM_CHANNEL]     = |group_nxt;
      summary_nxt[`SUM_AUX_MISSING] = sync2_r.aux_missing;
      summary_nxt[`SUM_PARAM]       = sync2_r.param_error | (|sync2_r.cfg_fault);
      led_nxt = group_nxt[1:0];
      rise    = |({summary_nxt, internal_nxt, ch0_nxt, ch1_nxt} & ~{summary_r, internal_r, ch0_r, ch1_r});
      stamp_nxt = rise ? tk.count : stamp_r;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         summary_r  <= `FAULT_RESET;
         internal_r <= `FAULT_RESET;
         group_r    <= `FAULT_RESET;
         ch0_r      <= `FAULT_RESET;
         ch1_r      <= `FAULT_RESET;
         stamp_r    <= `STAMP_RESET;
         led_r      <= 2'h0;
      end
      else
      begin
         summary_r  <= summary_nxt;
         internal_r <= internal_nxt;
         group_r    <= group_nxt;
         ch0_r      <= ch0_nxt;
         ch1_r      <= ch1_nxt;
         stamp_r    <= stamp_nxt;
         led_r      <= led_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   function automatic logic [7:0] sub_byte(input logic [7:0] sub, input logic [1:0] part);
      logic [7:0] b;
      b = `FAULT_RESET;
      case (sub)
         `OFS_SUMMARY  : b = summary_r;
         `OFS_CLASS    : b = `CLASS_VALUE;
         `OFS_INTERNAL : b = internal_r;
         `OFS_KIND     : b = `KIND_VALUE;
         `OFS_BITS     : b = `BITS_VALUE;
         `OFS_COUNT    : b = `COUNT_VALUE;
         `OFS_GROUP    : b = group_r;
         `OFS_CH0      : b = ch0_r;
         `OFS_CH1      : b = ch1_r;
         `OFS_STAMP    : b = 8'(stamp_r >> {part, 3'b000});
         default       : b = `FAULT_RESET;
      endcase
      return b;
   endfunction

   always_comb
   begin
      sel_sub  = 8'({3'b000, RD_BYTE}) + `OFS_SUMMARY;
      sel_part = RD_BYTE[1:0];
      sel_ok   = 1'b0;
      if (RD_BYTE >= `STAMP_FIRST_BYTE)
      begin
         sel_sub = `OFS_STAMP;
      end
      case (RD_MODE)
         ACC_RECORD :
         begin
            sel_ok = ((RD_SEL == `SET_FULL) && (RD_BYTE < `REC_LEN)) ||
                     ((RD_SEL == `SET_SHORT) && (RD_BYTE < `SHORT_LEN));
         end
         ACC_CANOPEN :
         begin
            sel_ok = ((RD_SEL == `CAN_FULL) && (RD_BYTE < `REC_LEN)) ||
                     ((RD_SEL == `CAN_SHORT) && (RD_BYTE < `SHORT_LEN));
         end
         ACC_ETHERCAT :
         begin
            sel_sub = RD_SUB;
            sel_ok  = (RD_SEL == `ECAT_INDEX) &&
                      (((RD_SUB >= `OFS_SUMMARY) && (RD_SUB <= `OFS_UNUSED_LAST)) ||
                       ((RD_SUB == `OFS_STAMP) && (RD_BYTE < `STAMP_LEN)));
         end
         default :
         begin
            sel_ok = 1'b0;
         end
      endcase
      ack_nxt  = RD_REQ;
      err_nxt  = RD_REQ & ~sel_ok;
      data_nxt = (RD_REQ && sel_ok) ? sub_byte(sel_sub, sel_part) : `FAULT_RESET;
      wref_nxt = WR_REQ;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ack_r  <= 1'b0;
         err_r  <= 1'b0;
         data_r <= `FAULT_RESET;
         wref_r <= 1'b0;
      end
      else
      begin
         ack_r  <= ack_nxt;
         err_r  <= err_nxt;
         data_r <= data_nxt;
         wref_r <= wref_nxt;
      end
   end

   assign RD_ACK     = ack_r;
   assign RD_ERR     = err_r;
   assign RD_DATA    = data_r;
   assign WR_REFUSED = wref_r;
   assign CH_LED     = led_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   led_follow_a: assert property (@(posedge CLK) disable iff (RESET)
      (CH_LED[0] == (ch0_r != 8'h00)) && (CH_LED[1] == (ch1_r != 8'h00)))
      else $error("channel indicator disagrees with fault byte");

   read_only_ack_a: assert property (@(posedge CLK) disable iff (RESET)
      RD_ACK |-> $past(RD_REQ))
      else $error("answer without a read");

   short_gate_a: assert property (@(posedge CLK) disable iff (RESET)
      ch0_r[`CH_SHORT_GND] |-> $past(SHORT_EN[0]) && $past(sync2_r.short_gnd[0]))
      else $error("short logged while detection disabled");

   short_set_limit_a: assert property (@(posedge CLK) disable iff (RESET)
      (RD_REQ && RD_MODE == ACC_RECORD && RD_SEL == `SET_SHORT && RD_BYTE >= `SHORT_LEN)
      |=> RD_ACK && RD_ERR && RD_DATA == 8'h00)
      else $error("short record set read past four bytes");

   can_kind_read_a: assert property (@(posedge CLK) disable iff (RESET)
      (RD_REQ && RD_MODE == ACC_CANOPEN && RD_SEL == `CAN_FULL && RD_BYTE == 5'h04)
      |=> RD_ACK && !RD_ERR && RD_DATA == 8'h73)
      else $error("full index read of channel kind failed");

   ecat_stamp_read_a: assert property (@(posedge CLK) disable iff (RESET)
      (RD_REQ && RD_MODE == ACC_ETHERCAT && RD_SEL == `ECAT_INDEX && RD_SUB == `OFS_STAMP
       && RD_BYTE == 5'h01) |=> !RD_ERR && RD_DATA == $past(stamp_r[15:8]))
      else $error("timestamp byte read wrongly");

   class_read_a: assert property (@(posedge CLK) disable iff (RESET)
      (RD_REQ && RD_MODE == ACC_ETHERCAT && RD_SEL == `ECAT_INDEX && RD_SUB == `OFS_CLASS)
      |=> RD_DATA == 8'h15)
      else $error("module class byte wrong");

   summary_shape_a: assert property (@(posedge CLK) disable iff (RESET)
      summary_r[6:5] == 2'b00 && summary_r[`SUM_CHANNEL] == (group_r != 8'h00))
      else $error("summary byte malformed");

   group_shape_a: assert property (@(posedge CLK) disable iff (RESET)
      group_r[7:2] == 6'h00 && group_r[0] == (ch0_r != 8'h00) && group_r[1] == (ch1_r != 8'h00))
      else $error("group byte disagrees with channel bytes");

   reserved_bits_a: assert property (@(posedge CLK) disable iff (RESET)
      internal_r[2:0] == 3'h0 && internal_r[7:5] == 3'h0 && ch0_r[7:4] == 4'h0 && ch0_r[2:1] == 2'h0)
      else $error("reserved bit set");

   stamp_capture_a: assert property (@(posedge CLK) disable iff (RESET)
      rise |=> stamp_r == $past(tk.count))
      else $error("timestamp not captured at event");

   tick_step_a: assert property (@(posedge CLK) disable iff (RESET)
      tk.tick |-> tk.count == $past(tk.count) + 32'h0000_0001)
      else $error("timestamp source missed a tick");

   write_refused_a: assert property (@(posedge CLK) disable iff (RESET)
      (WR_REQ && !RD_REQ) |=> WR_REFUSED && !RD_ACK)
      else $error("write not refused");

endmodule // analog_output_diag_record

//--- verif/diag_reader.sv
// Backplane reader model issuing record reads and write attempts
`timescale 1ns/1ps
module diag_reader
(
   input  wire logic            CLK,
   output diag_pkg::access_type RD_MODE,
   output logic                 RD_REQ,
   output logic [15:0]          RD_SEL,
   output logic [7:0]           RD_SUB,
   output logic [4:0]           RD_BYTE,
   output logic                 WR_REQ
);
   import diag_pkg::*;
   initial
   begin
      RD_REQ = 1'b0;
      WR_REQ = 1'b0;
      RD_MODE = ACC_RECORD;
      RD_SEL = 16'h0000;
      RD_SUB = 8'h00;
      RD_BYTE = 5'h00;
   end
   // One read per edge, back to back allowed
   task automatic req(input access_type m, input logic [15:0] sel, input logic [7:0] sub, input logic [4:0] b);
      @(posedge CLK);
      RD_REQ <= 1'b1;
      WR_REQ <= 1'b0;
      RD_MODE <= m;
      RD_SEL <= sel;
      RD_SUB <= sub;
      RD_BYTE <= b;
   endtask
   task automatic wr();
      @(posedge CLK);
      WR_REQ <= 1'b1;
      RD_REQ <= 1'b0;
   endtask
   // Released selectors show a changing pattern
   task automatic idle();
      @(posedge CLK);
      RD_REQ <= 1'b0;
      WR_REQ <= 1'b0;
      RD_SEL <= ~RD_SEL;
      RD_SUB <= ~RD_SUB;
      RD_BYTE <= ~RD_BYTE;
   endtask
endmodule // diag_reader

//--- verif/testbench.sv
// Self-checking bench for the analog output diagnostic record
`timescale 1ns/1ps
module testbench;
   import diag_pkg::*;
   localparam int CPU = 4;
   typedef struct {logic wr; logic err; logic [7:0] data; bit any;} note_type;
   logic        CLK, RESET, MODULE_FAIL, INT_ERROR, EXT_ERROR, AUX_MISSING, PARAM_ERROR;
   logic        BUF_OVERFLOW, COMM_ERROR, RD_REQ, WR_REQ, RD_ACK, RD_ERR, WR_REFUSED;
   logic [1:0]  CFG_FAULT, SHORT_GND, SHORT_EN, CH_LED;
   access_type  RD_MODE;
   logic [15:0] RD_SEL;
   logic [7:0]  RD_SUB, RD_DATA;
   logic [4:0]  RD_BYTE;
   logic [31:0] seed, ts_got, r;
   int          n_errors, compares, cyc, t;
   note_type    q[$];

   analog_output_diag_record #(.CYCLES_PER_US(CPU)) analog_output_diag_record_inst
   (
      .CLK(CLK), .RESET(RESET), .MODULE_FAIL(MODULE_FAIL), .INT_ERROR(INT_ERROR),
      .EXT_ERROR(EXT_ERROR), .AUX_MISSING(AUX_MISSING), .PARAM_ERROR(PARAM_ERROR),
      .BUF_OVERFLOW(BUF_OVERFLOW), .COMM_ERROR(COMM_ERROR), .CFG_FAULT(CFG_FAULT),
      .SHORT_GND(SHORT_GND), .SHORT_EN(SHORT_EN), .RD_REQ(RD_REQ), .RD_MODE(RD_MODE),
      .RD_SEL(RD_SEL), .RD_SUB(RD_SUB), .RD_BYTE(RD_BYTE), .WR_REQ(WR_REQ), .RD_ACK(RD_ACK),
      .RD_ERR(RD_ERR), .RD_DATA(RD_DATA), .WR_REFUSED(WR_REFUSED), .CH_LED(CH_LED)
   );
   diag_reader diag_reader_inst
   (
      .CLK(CLK), .RD_MODE(RD_MODE), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL), .RD_SUB(RD_SUB),
      .RD_BYTE(RD_BYTE), .WR_REQ(WR_REQ)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected record byte from the levels now on the fault inputs
   function automatic logic [7:0] exp_byte(input int b);
      logic [7:0] c0, c1, grp, intl, sum;
      c0 = {4'h0, SHORT_GND[0] & SHORT_EN[0], 2'b00, CFG_FAULT[0]};
      c1 = {4'h0, SHORT_GND[1] & SHORT_EN[1], 2'b00, CFG_FAULT[1]};
      grp = {6'h00, |c1, |c0};
      intl = {3'h0, COMM_ERROR, BUF_OVERFLOW, 3'h0};
      sum = {PARAM_ERROR | (|CFG_FAULT), 2'b00, AUX_MISSING, |grp, EXT_ERROR, INT_ERROR | (|intl), MODULE_FAIL};
      case (b)
         0: return sum;
         1: return 8'h15;
         3: return intl;
         4: return 8'h73;
         5: return 8'h08;
         6: return 8'h02;
         7: return grp;
         8: return c0;
         9: return c1;
         default: return 8'h00;
      endcase
   endfunction
   task automatic rd(input access_type m, input logic [15:0] sel, input logic [7:0] sub, input logic [4:0] b,
                     input logic err, input logic [7:0] d, input bit any);
      q.push_back('{1'b0, err, d, any});
      diag_reader_inst.req(m, sel, sub, b);
   endtask
   // Record byte b through mode m: 0 record set, 1 CANopen, 2 EtherCAT
   task automatic rd_all(input int m, input int b, input logic [31:0] ts, input bit any);
      logic [7:0] d;
      logic [31:0] x;
      x = xs();
      d = (b < 16) ? exp_byte(b) : ts[8*(b-16) +: 8];
      if (m == 0)
         rd(ACC_RECORD, 16'h0001, x[7:0], b[4:0], 1'b0, d, any);
      else if (m == 1)
         rd(ACC_CANOPEN, 16'h2F01, x[7:0], b[4:0], 1'b0, d, any);
      else if (b < 16)
         rd(ACC_ETHERCAT, 16'h5005, 8'(b + 2), x[4:0], 1'b0, d, any);
      else
         rd(ACC_ETHERCAT, 16'h5005, 8'h13, 5'(b - 16), 1'b0, d, any);
   endtask

   // ---------------------------------------------------------------
   // Clock, cycle count, answer monitor, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   always @(posedge CLK)
      cyc <= RESET ? 0 : cyc + 1;
   always @(posedge CLK)
   begin
      note_type n;
      if (RD_ACK === 1'b1 || WR_REFUSED === 1'b1)
      begin
         if (q.size() > 0)
            n = q.pop_front();
         else
            n = '{1'b1, 1'b1, 8'hFF, 1'b0};
         if (n.any)
         begin
            ts_got = {RD_DATA, ts_got[31:8]};
            check("stamp answer", {n.wr, n.err}, {WR_REFUSED, RD_ERR});
         end
         else
            check("answer", {n.wr, n.err, n.data}, {WR_REFUSED, RD_ERR, RD_DATA});
      end
   end
   initial
   begin
      repeat (50000) @(posedge CLK);
      n_errors++;
      test_done();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      seed = 32'h0BD6CC6D;
      {MODULE_FAIL, INT_ERROR, EXT_ERROR, AUX_MISSING, PARAM_ERROR, BUF_OVERFLOW, COMM_ERROR} = 7'h00;
      {CFG_FAULT, SHORT_GND, SHORT_EN} = 6'h00;
      RESET = 1'b1;
      cyc = 0;
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      for (int m = 0; m < 3; m++)
         for (int b = 0; b < 20; b++)
            rd_all(m, b, 32'h0000_0000, 1'b0);
      rd(ACC_RECORD, 16'h0000, 8'h00, 5'h03, 1'b0, exp_byte(3), 1'b0);
      rd(ACC_RECORD, 16'h0000, 8'h00, 5'h04, 1'b1, 8'h00, 1'b0);
      rd(ACC_CANOPEN, 16'h2F00, 8'h00, 5'h00, 1'b0, exp_byte(0), 1'b0);
      rd(ACC_CANOPEN, 16'h2F00, 8'h00, 5'h04, 1'b1, 8'h00, 1'b0);
      rd(ACC_ETHERCAT, 16'h5005, 8'h12, 5'h00, 1'b1, 8'h00, 1'b0);
      rd(ACC_ETHERCAT, 16'h5005, 8'h01, 5'h00, 1'b1, 8'h00, 1'b0);
      rd(ACC_ETHERCAT, 16'h5005, 8'h13, 5'h04, 1'b1, 8'h00, 1'b0);
      rd(ACC_RECORD, 16'h0001, 8'h00, 5'h14, 1'b1, 8'h00, 1'b0);
      rd(ACC_RECORD, 16'h1234, 8'h00, 5'h00, 1'b1, 8'h00, 1'b0);
      rd(access_type'(3'b011), 16'h0001, 8'h00, 5'h00, 1'b1, 8'h00, 1'b0);
      q.push_back('{1'b1, 1'b0, 8'h00, 1'b0});
      diag_reader_inst.wr();
      q.push_back('{1'b1, 1'b0, 8'h00, 1'b0});
      diag_reader_inst.wr();
      rd_all(0, 1, 32'h0, 1'b0);
      diag_reader_inst.idle();
      for (int i = 0; i < 24; i++)
      begin
         r = xs();
         @(posedge CLK);
         {MODULE_FAIL, INT_ERROR, EXT_ERROR, AUX_MISSING, PARAM_ERROR, BUF_OVERFLOW, COMM_ERROR} <= r[6:0];
         {CFG_FAULT, SHORT_GND, SHORT_EN} <= r[12:7];
         repeat (4) @(posedge CLK);
         #1;
         check("led", {CFG_FAULT[1] | (SHORT_GND[1] & SHORT_EN[1]), CFG_FAULT[0] | (SHORT_GND[0] & SHORT_EN[0])},
               CH_LED);
         for (int b = 0; b < 12; b++)
            rd_all(i % 3, b, 32'h0, 1'b0);
         diag_reader_inst.idle();
      end
      @(posedge CLK);
      {MODULE_FAIL, INT_ERROR, EXT_ERROR, AUX_MISSING, PARAM_ERROR, BUF_OVERFLOW, COMM_ERROR} <= 7'h00;
      {CFG_FAULT, SHORT_GND, SHORT_EN} <= 6'h00;
      repeat (6) @(posedge CLK);
      CFG_FAULT <= 2'b01;
      t = (cyc + 3) / CPU;
      repeat (6) @(posedge CLK);
      for (int b = 16; b < 20; b++)
         rd_all(2, b, 32'h0, 1'b1);
      diag_reader_inst.idle();
      repeat (4) @(posedge CLK);
      check("stamp range", 1, (int'(ts_got) >= t - 2) && (int'(ts_got) <= t + 2));
      check("notes left", 0, q.size());
      test_done();
   end
endmodule // testbench
